// >>> ecf_frame_encoder.sv
// vehicle charge parameter frame encoder with AXI4-Lite registers
//
// How it works
// - max battery voltage in bytes 4-5 of frame 100h, 1 V, every 100 ms.
// - rated capacity in bytes 5-6 of frame 101h, 0.11 kWh per bit.
// - byte 6 of frame 100h is always 100, the rate reference.
// - maximum charging time in 10 s units in byte 1 of 101h.
// - maximum charging time in minutes in byte 2 of 101h.
// - estimated remaining minutes in byte 3 of 101h, limited to 254.
// - protocol version number in byte 0 of frame 102h.
// - target inlet voltage in bytes 1-2 of 102h, limited to 600.
// - charging current request in byte 3 of 102h, refreshed every 100 ms.
// - charging rate percent in byte 6 of 102h, limited to 100.
// - byte 5 bit 0 of 102h is charge permission, 1 enabled.
// - byte 5 bit 1 of 102h is 1 when gear not in park.
// - byte 5 bit 2 of 102h flags a detected system malfunction.
// - byte 5 bit 3 of 102h is 1 once contactor open or weld done.
// - byte 5 bit 4 of 102h requests a normal stop.
// - byte 4 bit 0 of 102h flags battery overvoltage.
// - byte 4 bit 1 of 102h flags battery undervoltage.
// - byte 4 bits 2-4: current deviation, overtemperature, voltage deviation.
`timescale 1ns/1ns
module ecf_frame_encoder
	import ecf_pkg::*;
#(
	parameter int PERIOD_CYC = FRAME_PERIOD_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// frame stream towards the CAN controller
	output logic             txValid,
	input  wire logic        txReady,
	output logic [10:0]      txId,
	output logic [3:0]       txLen,
	output logic [63:0]      txData
);

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic        awHeld, next_awHeld, wHeld, next_wHeld;
	logic        bValidQ, next_bValidQ, rValidQ, next_rValidQ;
	logic [7:0]  awAddrQ, next_awAddrQ;
	logic [3:0]  wStrbQ, next_wStrbQ;
	logic [1:0]  bRespQ, next_bRespQ, rRespQ, next_rRespQ;
	logic [31:0] wDataQ, next_wDataQ, rDataQ, next_rDataQ;

	logic [31:0] regCtrl, next_regCtrl, regBatt, next_regBatt;
	logic [31:0] regTime, next_regTime, regTarget, next_regTarget;
	logic [31:0] regState, next_regState, statusWord, byteMask;
	logic        doWrite;

	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign s_axi_bvalid  = bValidQ;
	assign s_axi_bresp   = bRespQ;
	assign s_axi_arready = !rValidQ;
	assign s_axi_rvalid  = rValidQ;
	assign s_axi_rdata   = rDataQ;
	assign s_axi_rresp   = rRespQ;

	// held write data merged by its byte strobes, then cut to live bits
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] live);
		merge = ((old & ~byteMask) | (wDataQ & byteMask)) & live;
	endfunction

	// address and data are held separately, the write lands once both are in
	always_comb begin
		next_awHeld    = awHeld;
		next_awAddrQ   = awAddrQ;
		next_wHeld     = wHeld;
		next_wDataQ    = wDataQ;
		next_wStrbQ    = wStrbQ;
		next_bValidQ   = bValidQ;
		next_bRespQ    = bRespQ;
		next_regCtrl   = regCtrl;
		next_regBatt   = regBatt;
		next_regTime   = regTime;
		next_regTarget = regTarget;
		next_regState  = regState;
		byteMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
		doWrite = awHeld && wHeld && !bValidQ;
		if (s_axi_awvalid && !awHeld) begin
			next_awHeld  = 1'b1;
			next_awAddrQ = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld) begin
			next_wHeld  = 1'b1;
			next_wDataQ = s_axi_wdata;
			next_wStrbQ = s_axi_wstrb;
		end
		if (bValidQ && s_axi_bready) begin
			next_bValidQ = 1'b0;
		end
		if (doWrite) begin
			next_awHeld  = 1'b0;
			next_wHeld   = 1'b0;
			next_bValidQ = 1'b1;
			next_bRespQ  = RESP_OKAY;
			case (awAddrQ)
				OFS_CTRL:   next_regCtrl   = merge(regCtrl, MASK_CTRL);
				OFS_BATT:   next_regBatt   = merge(regBatt, MASK_BATT);
				OFS_TIME:   next_regTime   = merge(regTime, MASK_TIME);
				OFS_TARGET: next_regTarget = merge(regTarget, MASK_TARGET);
				OFS_STATE:  next_regState  = merge(regState, MASK_STATE);
				OFS_STATUS: next_bRespQ = RESP_OKAY; // read only, write dropped
				default: next_bRespQ = RESP_SLVERR;
			endcase
		end
	end

	// reads answer one cycle after the address is taken
	always_comb begin
		next_rValidQ = rValidQ;
		next_rDataQ  = rDataQ;
		next_rRespQ  = rRespQ;
		if (rValidQ && s_axi_rready) begin
			next_rValidQ = 1'b0;
		end
		if (s_axi_arvalid && !rValidQ) begin
			next_rValidQ = 1'b1;
			next_rRespQ  = RESP_OKAY;
			case (s_axi_araddr)
				OFS_CTRL:   next_rDataQ = regCtrl;
				OFS_BATT:   next_rDataQ = regBatt;
				OFS_TIME:   next_rDataQ = regTime;
				OFS_TARGET: next_rDataQ = regTarget;
				OFS_STATE:  next_rDataQ = regState;
				OFS_STATUS: next_rDataQ = statusWord;
				default: begin
					next_rDataQ = 32'h0000_0000;
					next_rRespQ = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awHeld    <= 1'b0;
			awAddrQ   <= 8'h00;
			wHeld     <= 1'b0;
			wDataQ    <= 32'h0000_0000;
			wStrbQ    <= 4'h0;
			bValidQ   <= 1'b0;
			bRespQ    <= RESP_OKAY;
			rValidQ   <= 1'b0;
			rDataQ    <= 32'h0000_0000;
			rRespQ    <= RESP_OKAY;
			regCtrl   <= RST_CTRL;
			regBatt   <= RST_BATT;
			regTime   <= RST_TIME;
			regTarget <= RST_TARGET;
			regState  <= RST_STATE;
		end else begin
			awHeld    <= next_awHeld;
			awAddrQ   <= next_awAddrQ;
			wHeld     <= next_wHeld;
			wDataQ    <= next_wDataQ;
			wStrbQ    <= next_wStrbQ;
			bValidQ   <= next_bValidQ;
			bRespQ    <= next_bRespQ;
			rValidQ   <= next_rValidQ;
			rDataQ    <= next_rDataQ;
			rRespQ    <= next_rRespQ;
			regCtrl   <= next_regCtrl;
			regBatt   <= next_regBatt;
			regTime   <= next_regTime;
			regTarget <= next_regTarget;
			regState  <= next_regState;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// refresh period

	ecf_tick_if tk ();

	assign tk.enable = regCtrl[CTRL_EN_BIT];

	ecf_tick_div #(.PERIOD_CYC(PERIOD_CYC)) ecf_tick_div_inst (
		.clk(clk), .resetn(resetn), .tk(tk));

	////////////////////////////////////////////////////////////////////////
	// frame packing

	// byte b of the payload sits at bits 8*b+7 .. 8*b, all else zero
	function automatic logic [63:0] pack(input logic [1:0] idx,
		input logic [31:0] b, input logic [31:0] t,
		input logic [31:0] g, input logic [31:0] s);
		logic [63:0] d;
		logic [7:0]  est, rate;
		logic [15:0] volt;
		d    = 64'h0;
		est  = t[TIME_EST_LSB +: 8];
		volt = g[TGT_VOLT_LSB +: 16];
		rate = s[STATE_RATE_LSB +: 8];
		case (idx)
			2'd0: begin
				d[39:32] = b[BATT_VMAX_LSB +: 8];
				d[47:40] = b[BATT_VMAX_LSB + 8 +: 8];
				d[55:48] = RATE_REF;
			end
			2'd1: begin
				d[15:8]  = t[TIME_T10S_LSB +: 8];
				d[23:16] = t[TIME_TMIN_LSB +: 8];
				d[31:24] = (est > EST_MAX) ? EST_MAX : est;
				d[47:40] = b[BATT_CAP_LSB +: 8];
				d[55:48] = b[BATT_CAP_LSB + 8 +: 8];
			end
			2'd2: begin
				d[7:0] = g[TGT_PROTO_LSB +: 8];
				if (volt > VOLT_MAX) begin
					volt = VOLT_MAX;
				end
				d[23:8]  = volt;
				d[31:24] = g[TGT_CURR_LSB +: 8];
				// fault flags: overvolt, undervolt, current, temp, volt dev
				d[36:32] = s[STATE_FLT_LSB +: 5];
				// status: enable, shift, fault, contactor, stop request
				d[44:40] = s[STATE_FLAG_LSB +: 5];
				d[55:48] = (rate > RATE_MAX) ? RATE_MAX : rate;
			end
			default: d = 64'h0;
		endcase
		pack = d;
	endfunction

	function automatic logic [10:0] frameIdOf(input logic [1:0] idx);
		case (idx)
			2'd0:    frameIdOf = ID_LIMITS;
			2'd1:    frameIdOf = ID_TIMES;
			default: frameIdOf = ID_LIVE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// frame sequencer

	ecf_send_t   sendState, next_sendState;
	logic [1:0]  frameIdx, next_frameIdx;
	logic        txValidQ, next_txValidQ;
	logic [10:0] txIdQ, next_txIdQ;
	logic [63:0] txDataQ, next_txDataQ;
	logic [7:0]  sentCount, next_sentCount, overrunCount, next_overrunCount;

	assign txValid = txValidQ;
	assign txId    = txIdQ;
	assign txLen   = FRAME_LEN;
	assign txData  = txDataQ;

	assign statusWord = {8'h00, overrunCount, sentCount, 4'h0,
		frameIdx, 1'b0, (sendState == SEND_BUSY)};

	// each tick taken in SEND_IDLE sends 100h, 101h, 102h in turn; payload is frozen once offered
	always_comb begin
		next_sendState    = sendState;
		next_frameIdx     = frameIdx;
		next_txValidQ     = txValidQ;
		next_txIdQ        = txIdQ;
		next_txDataQ      = txDataQ;
		next_sentCount    = sentCount;
		next_overrunCount = overrunCount;
		case (sendState)
			SEND_IDLE: begin
				if (tk.tick) begin
					next_sendState = SEND_BUSY;
					next_frameIdx  = 2'd0;
					next_txValidQ  = 1'b1;
					next_txIdQ     = frameIdOf(2'd0);
					next_txDataQ   = pack(2'd0, regBatt, regTime, regTarget, regState);
				end
			end
			SEND_BUSY: begin
				// a slow bus must not stack periods; the lost one is counted
				if (tk.tick) begin
					next_overrunCount = overrunCount + 8'h01;
				end
				if (txValidQ && txReady) begin
					next_sentCount = sentCount + 8'h01;
					if (frameIdx == 2'd2) begin
						next_sendState = SEND_IDLE;
						next_txValidQ  = 1'b0;
					end else begin
						next_frameIdx = frameIdx + 2'd1;
						next_txIdQ    = frameIdOf(frameIdx + 2'd1);
						next_txDataQ  = pack(frameIdx + 2'd1, regBatt,
							regTime, regTarget, regState);
					end
				end
			end
			default: begin
				next_sendState = SEND_IDLE;
				next_txValidQ  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sendState    <= SEND_IDLE;
			frameIdx     <= 2'd0;
			txValidQ     <= 1'b0;
			txIdQ        <= 11'h000;
			txDataQ      <= 64'h0;
			sentCount    <= 8'h00;
			overrunCount <= 8'h00;
		end else begin
			sendState    <= next_sendState;
			frameIdx     <= next_frameIdx;
			txValidQ     <= next_txValidQ;
			txIdQ        <= next_txIdQ;
			txDataQ      <= next_txDataQ;
			sentCount    <= next_sentCount;
			overrunCount <= next_overrunCount;
		end
	end

endmodule // ecf_frame_encoder

// >>> ecf_frame_encoder_bench.sv
// self-checking bench for the frame encoder
`timescale 1ns/1ns
module ecf_frame_encoder_bench
	import ecf_pkg::*;
;
	localparam int P = 50;
	logic        clk, resetn, stall, txValid, txReady;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
	logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
	logic        s_axi_arvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb, txLen;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [10:0] txId;
	logic [63:0] txData, lim, tim, liv;
	int          sets, gap, errCount, cmpCount;

	ecf_frame_encoder #(.PERIOD_CYC(P)) ecf_frame_encoder_inst (.clk,
		.resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .txValid, .txReady, .txId, .txLen,
		.txData);
	ecf_station_model ecf_station_model_inst (.clk, .resetn, .stall,
		.txValid, .txId, .txData, .txReady, .lim, .tim, .liv, .sets, .gap);

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] s, input logic [63:0] e);
		cmpCount++;
		if (s !== e) begin
			errCount++;
			$display("mismatch %0t: got %h exp %h", $time, s, e);
		end
	endtask

	task endOfTest;
		$display("checks %0d, mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task tmo;
		errCount++;
		$display("mismatch %0t: wait ran out", $time);
		endOfTest;
	endtask

	// write: address and data offered together, each dropped when taken
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 200);
		if (!s_axi_bvalid) tmo;
		chk(s_axi_bresp, r);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 200);
		if (!s_axi_rvalid) tmo;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// two full sets, so the last one was loaded after any write
	task wset;
		int n;
		int k;
		k = sets;
		for (n = 0; n < 400 && sets < k + 2; n++) @(posedge clk);
		if (sets < k + 2) tmo;
	endtask

	////////////////////////////////////////////////////////////////////////
	task scenRegs;
		int i;
		for (i = 0; i < 24; i += 4) axr(i[7:0], 32'h0, RESP_OKAY);
		axw(OFS_STATE, 32'hffff_ffff, 4'hf, RESP_OKAY);
		axr(OFS_STATE, MASK_STATE, RESP_OKAY);
		axw(OFS_BATT, 32'h1234_5678, 4'hf, RESP_OKAY);
		axw(OFS_BATT, 32'hffff_ffff, 4'h2, RESP_OKAY);
		axr(OFS_BATT, 32'h1234_ff78, RESP_OKAY);
		axw(OFS_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
		axr(OFS_STATUS, 32'h0, RESP_OKAY);
		axw(8'h20, 32'h1, 4'hf, RESP_SLVERR);
		axr(8'h20, 32'h0, RESP_SLVERR);
	endtask

	// over-range estimate, voltage and rate; first frame held by a stall
	task scenFields;
		axw(OFS_BATT, 32'h1234_01a5, 4'hf, RESP_OKAY);
		axw(OFS_TIME, 32'h00ff_2afe, 4'hf, RESP_OKAY);
		axw(OFS_TARGET, 32'h7d03_0003, 4'hf, RESP_OKAY);
		axw(OFS_STATE, 32'h0000_0080, 4'hf, RESP_OKAY);
		axw(OFS_CTRL, 32'h1, 4'hf, RESP_OKAY);
		stall <= 1'b1;
		repeat (60) @(posedge clk);
		stall <= 1'b0;
		wset;
		chk(lim, {8'h00, 8'h64, 16'h01a5, 32'h0});
		chk(tim, {8'h0, 16'h1234, 8'h0, 8'hfe, 8'h2a, 8'hfe, 8'h0});
		chk(liv, {16'h0064, 16'h0, 8'h7d, 16'h0258, 8'h03});
	endtask

	// walk a single one through every flag and fault bit
	task scenFlags;
		int i;
		logic [15:0] f;
		for (i = 0; i < 10; i++) begin
			f = 16'h1 << i;
			axw(OFS_STATE, {11'h0, f[9:5], 3'h0, f[4:0], 8'h63}, 4'hf,
				RESP_OKAY);
			wset;
			chk(liv, {16'h0063, 3'h0, f[4:0], 3'h0, f[9:5], 8'h7d, 16'h0258, 8'h03});
		end
		chk(64'(gap), 64'(P));
	endtask

	// clearing enable lets the set in flight finish, then the stream is quiet
	task scenStop;
		int k;
		axw(OFS_CTRL, 32'h0, 4'hf, RESP_OKAY);
		repeat (10) @(posedge clk);
		k = sets;
		repeat (3 * P) @(posedge clk);
		chk(64'(sets), 64'(k));
		// idle, last index 2, three frames per set, no lost period
		axr(OFS_STATUS, {16'h0, 8'(3 * k), 8'h08}, RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// inputs quiet at time zero, reset for ten cycles
	initial begin
		errCount = 0;
		cmpCount = 0;
		{resetn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_wstrb} = '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		scenRegs;
		scenFields;
		scenFlags;
		scenStop;
		endOfTest;
	end
endmodule // ecf_frame_encoder_bench

bind ecf_frame_encoder ecf_frame_encoder_monitor ecf_frame_encoder_monitor_inst (
	.clk, .resetn, .txValid, .txReady, .txId, .txLen, .txData);

// >>> ecf_frame_encoder_monitor.sv
// concurrent checks on the frame stream of the encoder
`timescale 1ns/1ns
module ecf_frame_encoder_monitor
	import ecf_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        txValid,
	input wire logic        txReady,
	input wire logic [10:0] txId,
	input wire logic [3:0]  txLen,
	input wire logic [63:0] txData
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// which frame is on offer
	wire logic isLim = txValid && txId == ID_LIMITS;
	wire logic isTim = txValid && txId == ID_TIMES;
	wire logic isLiv = txValid && txId == ID_LIVE;

	////////////////////////////////////////////////////////////////////////
	a_len_fixed: assert property (txValid |-> txLen == FRAME_LEN &&
		(isLim || isTim || isLiv))
		else $error("frame length or identifier wrong");
	// a stalled station must see the same frame again
	a_frame_hold: assert property (txValid && !txReady |=>
		txValid && $stable(txId) && $stable(txData))
		else $error("frame changed before it was taken");
	a_order_times: assert property (isLim && txReady |=> isTim)
		else $error("times frame does not follow limits frame");
	a_order_live: assert property (isTim && txReady |=> isLiv)
		else $error("live frame does not follow times frame");
	a_limits_fill: assert property (isLim |-> txData[55:48] == 8'h64 &&
		txData[31:0] == 32'h0 && txData[63:56] == 8'h0)
		else $error("limits frame reference or spare bytes wrong");
	a_est_clamp: assert property (isTim |-> txData[31:24] <= EST_MAX &&
		txData[7:0] == 8'h0 && txData[63:56] == 8'h0)
		else $error("estimate above limit or spare byte set");
	a_volt_clamp: assert property (isLiv |-> txData[23:8] <= 16'd600)
		else $error("target voltage above limit");
	a_rate_clamp: assert property (isLiv |-> txData[55:48] <= 8'd100 &&
		txData[63:56] == 8'h0)
		else $error("charging rate above limit");
	a_flag_spare: assert property (isLiv |-> txData[47:45] == 3'h0 &&
		txData[39:37] == 3'h0)
		else $error("unused flag bits set");

	// main scenarios reached
	c_stall: cover property (txValid && !txReady);
	c_live_taken: cover property (isLiv && txReady);
	c_volt_clamped: cover property (isLiv && txData[23:8] == 16'd600);
endmodule // ecf_frame_encoder_monitor

// >>> ecf_pkg.sv
// shared constants for the charge parameter frame encoder
package ecf_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BATT   = 8'h04;
	localparam logic [7:0] OFS_TIME   = 8'h08;
	localparam logic [7:0] OFS_TARGET = 8'h0c;
	localparam logic [7:0] OFS_STATE  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// writable bits of each register; the rest read as zero
	localparam logic [31:0] MASK_CTRL   = 32'h0000_0001;
	localparam logic [31:0] MASK_BATT   = 32'hffff_ffff;
	localparam logic [31:0] MASK_TIME   = 32'h00ff_ffff;
	localparam logic [31:0] MASK_TARGET = 32'hffff_ffff;
	localparam logic [31:0] MASK_STATE  = 32'h001f_1fff;

	// reset values
	localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
	localparam logic [31:0] RST_BATT   = 32'h0000_0000;
	localparam logic [31:0] RST_TIME   = 32'h0000_0000;
	localparam logic [31:0] RST_TARGET = 32'h0000_0000;
	localparam logic [31:0] RST_STATE  = 32'h0000_0000;

	// field positions inside the registers
	localparam int CTRL_EN_BIT    = 0;
	localparam int BATT_VMAX_LSB  = 0;
	localparam int BATT_CAP_LSB   = 16;
	localparam int TIME_T10S_LSB  = 0;
	localparam int TIME_TMIN_LSB  = 8;
	localparam int TIME_EST_LSB   = 16;
	localparam int TGT_PROTO_LSB  = 0;
	localparam int TGT_VOLT_LSB   = 8;
	localparam int TGT_CURR_LSB   = 24;
	localparam int STATE_RATE_LSB = 0;
	localparam int STATE_FLAG_LSB = 8;
	localparam int STATE_FLT_LSB  = 16;

	// frame identifiers and limits
	localparam logic [10:0] ID_LIMITS = 11'h100;
	localparam logic [10:0] ID_TIMES  = 11'h101;
	localparam logic [10:0] ID_LIVE   = 11'h102;
	localparam logic [3:0]  FRAME_LEN = 4'h8;
	localparam logic [7:0]  RATE_REF  = 8'h64;
	localparam logic [7:0]  EST_MAX   = 8'hfe;
	localparam logic [15:0] VOLT_MAX  = 16'h0258;
	localparam logic [7:0]  RATE_MAX  = 8'h64;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// timing
	localparam int CLK_FREQ_HZ      = 10_000_000;
	localparam int FRAME_PERIOD_MS  = 100;
	localparam int FRAME_PERIOD_CYC = CLK_FREQ_HZ / 1000 * FRAME_PERIOD_MS;

	typedef enum logic [1:0] {
		SEND_IDLE,
		SEND_BUSY
	} ecf_send_t;

endpackage

// >>> ecf_station_model.sv
// station side: accepts frames, keeps the last payload of each id
`timescale 1ns/1ns
module ecf_station_model
	import ecf_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        stall,
	input wire logic        txValid,
	input wire logic [10:0] txId,
	input wire logic [63:0] txData,
	output logic            txReady,
	output logic [63:0]     lim,
	output logic [63:0]     tim,
	output logic [63:0]     liv,
	output int              sets,
	output int              gap
);
	int cyc;
	int t0;

	// ready lags the stall request by a cycle, like a busy controller
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txReady <= 1'b0;
			cyc <= 0;
			t0 <= 0;
			sets <= 0;
		end else begin
			txReady <= !stall;
			cyc <= cyc + 1;
			if (txValid && txReady) begin
				case (txId)
					ID_LIMITS: begin
						lim <= txData;
						gap <= cyc - t0;
						t0 <= cyc;
					end
					ID_TIMES: tim <= txData;
					ID_LIVE: begin
						liv <= txData;
						sets <= sets + 1;
					end
					default: ;
				endcase
			end
		end
	end
endmodule // ecf_station_model

// >>> ecf_tick_div.sv
// refresh period divider producing a one-cycle enable pulse
`timescale 1ns/1ns
module ecf_tick_div
	import ecf_pkg::*;
#(
	parameter int PERIOD_CYC = FRAME_PERIOD_CYC
) (
	input  wire logic   clk,
	input  wire logic   resetn,
	ecf_tick_if.divider tk
);
	localparam int CW = $clog2(PERIOD_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          pulse;
	logic          next_pulse;

	// free count while enabled; restarting keeps the first frame a period away
	always_comb begin
		next_count = count;
		next_pulse = 1'b0;
		if (!tk.enable) begin
			next_count = '0;
		end else if (count == LAST) begin
			next_count = '0;
			next_pulse = 1'b1;
		end else begin
			next_count = count + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			pulse <= 1'b0;
		end else begin
			count <= next_count;
			pulse <= next_pulse;
		end
	end

	assign tk.tick = pulse;
endmodule // ecf_tick_div

// >>> ecf_tick_if.sv
// carrier between the encoder and its refresh divider
`timescale 1ns/1ns
interface ecf_tick_if;
	logic enable;
	logic tick;
	modport divider (input enable, output tick);
	modport user    (output enable, input tick);
endinterface
